// File: common/mdsr_pkg.sv
package mdsr_pkg;

    localparam int STATUS_BITS  = 24;
    localparam int NUM_CHAN     = 8;
    localparam int CHAN_BITS_HI = 24;
    localparam int CHAN_BITS_LO = 16;
    localparam int CHAN_RAW_W   = NUM_CHAN * CHAN_BITS_HI;
    localparam int FRAME_MAX    = STATUS_BITS + CHAN_RAW_W;
    localparam int CMD_BITS     = 8;
    localparam int REG_BITS     = 8;
    localparam int RATE_W       = 3;

    localparam logic [7:0] CMD_START = 8'h08;
    localparam logic [7:0] CMD_RDATA = 8'h12;
    localparam logic [7:0] CMD_RREG1 = 8'h21;
    localparam logic [7:0] CMD_WREG1 = 8'h41;

    // Fields of first_config_register.
    localparam int CFG_CHAIN_BIT  = 6;
    localparam int CFG_CLKOUT_BIT = 5;
    localparam int CFG_RATE_LSB   = 0;
    localparam logic [7:0] CFG1_RESET = 8'h00;
    // Rate codes up to this value deliver short channel words.
    localparam logic [RATE_W-1:0] RATE_LOWRES_MAX = 3'h1;

    typedef enum logic [3:0] {
        PH_CMD   = 4'h1,
        PH_WDATA = 4'h2,
        PH_SHIFT = 4'h4,
        PH_IDLE  = 4'h8
    } mdsr_dphase_e;

    typedef enum logic [2:0] {
        HS_IDLE  = 3'h1,
        HS_SHIFT = 3'h2,
        HS_TAIL  = 3'h4
    } mdsr_hstate_e;

    function automatic logic mdsrLowRes(input logic [RATE_W-1:0] rate);
        return rate <= RATE_LOWRES_MAX;
    endfunction

    function automatic int mdsrChanBits(input logic [RATE_W-1:0] rate);
        return mdsrLowRes(rate) ? CHAN_BITS_LO : CHAN_BITS_HI;
    endfunction

    function automatic int mdsrFrameBits(input logic [RATE_W-1:0] rate);
        return STATUS_BITS + NUM_CHAN * mdsrChanBits(rate);
    endfunction

endpackage

// File: common/mdsr_if.sv
`timescale 1ns/1ps
interface mdsr_if #(parameter int N_DEV = 2);
    logic             sclk;
    logic             din;
    logic [N_DEV-1:0] csN;
    logic [N_DEV-1:0] devDout;
    logic [N_DEV-1:0] devDoutOe;
    logic [N_DEV-1:0] chainIn;
    logic             busDout;
    logic             chainWired;

    // Each device hears the one behind it; the last one hears ground.
    for (genvar i = 0; i < N_DEV; i++) begin : g_link
        assign chainIn[i] = (i == N_DEV - 1) ? 1'b0 : devDout[(i + 1) % N_DEV];
    end

    // Chain wiring takes only the first output to the host; the others feed chain inputs.
    assign busDout = chainWired ? (devDout[0] & devDoutOe[0]) : |(devDout & devDoutOe);

    modport device (input sclk, input din, input csN, input chainIn, output devDout, output devDoutOe);
    modport host (output sclk, output din, output csN, output chainWired, input busDout);
endinterface

// File: design/mdsr_device.sv
`timescale 1ns/1ps
module mdsr_device #(
    parameter int DEV_IDX = 0
) (
    mdsr_if.device                                   lnk,
    input  wire logic                                core_clk,
    input  wire logic                                reset,
    input  wire logic                                sampleValid,
    input  wire logic [mdsr_pkg::STATUS_BITS-1:0]    sampleStatus,
    input  wire logic [mdsr_pkg::CHAN_RAW_W-1:0]     sampleChans,
    output logic                                     sampleReady,
    output logic                                     chainMode,
    output logic [mdsr_pkg::RATE_W-1:0]              rateSelect,
    output logic                                     oscClkOutEn,
    output logic                                     convStart
);

    localparam int FM = mdsr_pkg::FRAME_MAX;
    localparam logic [3:0] CMD_LAST = 4'(mdsr_pkg::CMD_BITS - 1);
    localparam logic [3:0] REG_LAST = 4'(mdsr_pkg::REG_BITS - 1);

    typedef struct packed {
        logic          rstHold;
        logic [FM-1:0] hold;
        logic          req;
        logic          ackS1;
        logic          ackS2;
        logic          cfgS1;
        logic          cfgS2;
        logic          cfgSeen;
        logic [7:0]    cfgCopy;
        logic          stS1;
        logic          stS2;
        logic          stSeen;
        logic          convStart;
    } mdsr_dcore_s;

    typedef struct packed {
        logic [7:0]    cfg1;
        logic          reqS1;
        logic          reqS2;
        logic          ack;
        logic [FM-1:0] copy;
        logic          cfgTog;
        logic          startTog;
    } mdsr_dcfg_s;

    typedef struct packed {
        mdsr_pkg::mdsr_dphase_e phase;
        logic [3:0]             bitCnt;
        logic [7:0]             cmd;
        logic [FM-1:0]          shreg;
        logic [7:0]             insPos;
        logic                   fwd;
        logic                   chainCap;
    } mdsr_dframe_s;

    mdsr_dcore_s  co_r;
    mdsr_dcore_s  co_nxt;
    mdsr_dcfg_s   cf_r;
    mdsr_dcfg_s   cf_nxt;
    mdsr_dframe_s fr_r;
    mdsr_dframe_s fr_nxt;
    logic         frameClr;
    logic [7:0]   newCmd;

    // Short channel words keep the upper bits of each full-width sample.
    function automatic logic [FM-1:0] packFrame(input logic [FM-1:0] raw, input logic lowRes);
        logic [FM-1:0] f;
        f = raw;
        if (lowRes) begin
            f = '0;
            f[FM-1 -: mdsr_pkg::STATUS_BITS] = raw[FM-1 -: mdsr_pkg::STATUS_BITS];
            for (int c = 0; c < mdsr_pkg::NUM_CHAN; c++) begin
                f[FM-1-mdsr_pkg::STATUS_BITS-c*mdsr_pkg::CHAN_BITS_LO -: mdsr_pkg::CHAN_BITS_LO] =
                    raw[FM-1-mdsr_pkg::STATUS_BITS-c*mdsr_pkg::CHAN_BITS_HI -: mdsr_pkg::CHAN_BITS_LO];
            end
        end
        return f;
    endfunction

    // Core side: sample hand-off, configuration and start crossing.
    assign sampleReady = (co_r.req == co_r.ackS2);

    always_comb begin
        co_nxt           = co_r;
        co_nxt.rstHold   = reset;
        co_nxt.ackS1     = cf_r.ack;
        co_nxt.ackS2     = co_r.ackS1;
        co_nxt.cfgS1     = cf_r.cfgTog;
        co_nxt.cfgS2     = co_r.cfgS1;
        co_nxt.stS1      = cf_r.startTog;
        co_nxt.stS2      = co_r.stS1;
        co_nxt.convStart = 1'b0;
        if (sampleValid && sampleReady) begin
            co_nxt.hold = {sampleStatus, sampleChans};
            co_nxt.req  = ~co_r.req;
        end
        // The link register is stable long before its toggle arrives here.
        if (co_r.cfgS2 != co_r.cfgSeen) begin
            co_nxt.cfgSeen = co_r.cfgS2;
            co_nxt.cfgCopy = cf_r.cfg1;
        end
        if (co_r.stS2 != co_r.stSeen) begin
            co_nxt.stSeen    = co_r.stS2;
            co_nxt.convStart = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            co_r         <= '0;
            co_r.rstHold <= 1'b1;
            co_r.cfgCopy <= mdsr_pkg::CFG1_RESET;
        end else begin
            co_r <= co_nxt;
        end
    end

    assign chainMode   = co_r.cfgCopy[mdsr_pkg::CFG_CHAIN_BIT];
    assign rateSelect  = co_r.cfgCopy[mdsr_pkg::CFG_RATE_LSB +: mdsr_pkg::RATE_W];
    assign oscClkOutEn = co_r.cfgCopy[mdsr_pkg::CFG_CLKOUT_BIT] & ~chainMode;
    assign convStart   = co_r.convStart;

    // Link side: the shift logic runs only while the serial clock runs.
    assign newCmd = {fr_r.cmd[6:0], lnk.din};

    always_comb begin
        cf_nxt          = cf_r;
        fr_nxt          = fr_r;
        cf_nxt.reqS1    = co_r.req;
        cf_nxt.reqS2    = cf_r.reqS1;
        fr_nxt.chainCap = lnk.chainIn[DEV_IDX];
        // A fresh sample is frozen on the core side until this acknowledge returns.
        if (cf_r.reqS2 != cf_r.ack) begin
            cf_nxt.copy = co_r.hold;
            cf_nxt.ack  = ~cf_r.ack;
        end
        unique case (fr_r.phase)
            mdsr_pkg::PH_CMD: begin
                fr_nxt.cmd    = newCmd;
                fr_nxt.bitCnt = fr_r.bitCnt + 4'h1;
                if (fr_r.bitCnt == CMD_LAST) begin
                    fr_nxt.bitCnt = 4'h0;
                    fr_nxt.phase  = mdsr_pkg::PH_IDLE;
                    if (newCmd == mdsr_pkg::CMD_WREG1) begin
                        fr_nxt.phase = mdsr_pkg::PH_WDATA;
                    end else if (newCmd == mdsr_pkg::CMD_RREG1) begin
                        fr_nxt.shreg = {cf_r.cfg1, {(FM - mdsr_pkg::REG_BITS){1'b0}}};
                        fr_nxt.fwd   = 1'b0;
                        fr_nxt.phase = mdsr_pkg::PH_SHIFT;
                    end else if (newCmd == mdsr_pkg::CMD_RDATA) begin
                        fr_nxt.shreg  = packFrame(cf_r.copy,
                                            mdsr_pkg::mdsrLowRes(cf_r.cfg1[mdsr_pkg::CFG_RATE_LSB +: mdsr_pkg::RATE_W]));
                        fr_nxt.insPos = 8'(FM - mdsr_pkg::mdsrFrameBits(
                                            cf_r.cfg1[mdsr_pkg::CFG_RATE_LSB +: mdsr_pkg::RATE_W]));
                        fr_nxt.fwd    = cf_r.cfg1[mdsr_pkg::CFG_CHAIN_BIT];
                        fr_nxt.phase  = mdsr_pkg::PH_SHIFT;
                    end else if (newCmd == mdsr_pkg::CMD_START) begin
                        cf_nxt.startTog = ~cf_r.startTog;
                    end
                end
            end
            mdsr_pkg::PH_WDATA: begin
                fr_nxt.cmd    = newCmd;
                fr_nxt.bitCnt = fr_r.bitCnt + 4'h1;
                if (fr_r.bitCnt == REG_LAST) begin
                    // Every device on the shared select takes the same write.
                    cf_nxt.cfg1   = newCmd;
                    cf_nxt.cfgTog = ~cf_r.cfgTog;
                    fr_nxt.phase  = mdsr_pkg::PH_IDLE;
                end
            end
            mdsr_pkg::PH_SHIFT: begin
                fr_nxt.shreg = {fr_r.shreg[FM-2:0], 1'b0};
                // The captured bit enters one clock late, which yields the spare bit.
                if (fr_r.fwd) begin
                    fr_nxt.shreg[fr_r.insPos] = fr_r.chainCap;
                end
            end
            mdsr_pkg::PH_IDLE: begin
                fr_nxt.bitCnt = fr_r.bitCnt;
            end
        endcase
    end

    always_ff @(posedge lnk.sclk or posedge co_r.rstHold) begin
        if (co_r.rstHold) begin
            cf_r      <= '0;
            cf_r.cfg1 <= mdsr_pkg::CFG1_RESET;
        end else begin
            cf_r <= cf_nxt;
        end
    end

    // A raised select ends the frame even though the clock has stopped.
    assign frameClr = lnk.csN[DEV_IDX] | co_r.rstHold;

    always_ff @(posedge lnk.sclk or posedge frameClr) begin
        if (frameClr) begin
            fr_r       <= '0;
            fr_r.phase <= mdsr_pkg::PH_CMD;
        end else begin
            fr_r <= fr_nxt;
        end
    end

    assign lnk.devDout[DEV_IDX]   = fr_r.shreg[FM-1] & (fr_r.phase == mdsr_pkg::PH_SHIFT);
    assign lnk.devDoutOe[DEV_IDX] = ~lnk.csN[DEV_IDX];

endmodule // mdsr_device

// File: design/mdsr_host.sv
`timescale 1ns/1ps
module mdsr_host #(
    parameter int N_DEV        = 2,
    parameter int DIV_HALF     = 4,
    parameter int CORE_HZ      = 25000000,
    parameter int DATA_RATE_HZ = 8000
) (
    input  wire logic                                core_clk,
    input  wire logic                                reset,
    mdsr_if.host                                     lnk,
    input  wire logic                                cmdValid,
    input  wire logic [7:0]                          cmdOp,
    input  wire logic [7:0]                          cmdData,
    input  wire logic [$clog2(N_DEV+1)-1:0]          cmdDev,
    output logic                                     cmdReady,
    output logic                                     rxValid,
    output logic [mdsr_pkg::STATUS_BITS-1:0]         rxWord,
    output logic [$clog2(N_DEV+1)-1:0]               rxDev,
    output logic [3:0]                               rxChan,
    output logic                                     rdValid,
    output logic [7:0]                               rdData,
    output logic                                     convStartPin,
    output logic                                     chainTooLong
);

    localparam int DW     = $clog2(N_DEV + 1);
    localparam int MAXB   = mdsr_pkg::CMD_BITS + N_DEV * (mdsr_pkg::FRAME_MAX + 1);
    localparam int FW     = $clog2(MAXB + 1);
    localparam int SCLK_HZ = CORE_HZ / (2 * DIV_HALF);
    localparam logic TOO_LONG = (longint'(N_DEV) * mdsr_pkg::FRAME_MAX * DATA_RATE_HZ) > longint'(SCLK_HZ);
    localparam logic [7:0] DIV_LAST = 8'(DIV_HALF - 1);

    typedef struct packed {
        mdsr_pkg::mdsr_hstate_e    state;
        logic [7:0]                div;
        logic                      sclk;
        logic [N_DEV-1:0]          csN;
        logic                      din;
        logic [15:0]               tx;
        logic [7:0]                op;
        logic [FW-1:0]             falls;
        logic [FW-1:0]             total;
        logic [7:0]                setBit;
        logic [4:0]                wordBit;
        logic [3:0]                wordIdx;
        logic [DW-1:0]             devIdx;
        logic [23:0]               rxSh;
        logic                      rxValid;
        logic [23:0]               rxWord;
        logic                      rdValid;
        logic [7:0]                rdData;
        logic                      chain;
        logic [2:0]                rate;
        logic                      doS1;
        logic                      doS2;
        logic                      tooLong;
    } mdsr_host_s;

    mdsr_host_s hs_r;
    mdsr_host_s hs_nxt;
    logic [7:0] fb;
    logic [4:0] wlen;
    logic [7:0] wrData;

    assign fb   = 8'(mdsr_pkg::mdsrFrameBits(hs_r.rate));
    assign wlen = (hs_r.wordIdx == 4'h0) ? 5'(mdsr_pkg::STATUS_BITS) : 5'(mdsr_pkg::mdsrChanBits(hs_r.rate));
    // Chain mode never turns the oscillator output on.
    assign wrData = cmdData[mdsr_pkg::CFG_CHAIN_BIT] ?
                    (cmdData & ~(8'h01 << mdsr_pkg::CFG_CLKOUT_BIT)) : cmdData;

    always_comb begin
        hs_nxt         = hs_r;
        hs_nxt.rxValid = 1'b0;
        hs_nxt.rdValid = 1'b0;
        hs_nxt.doS1    = lnk.busDout;
        hs_nxt.doS2    = hs_r.doS1;
        hs_nxt.tooLong = TOO_LONG;
        unique case (hs_r.state)
            mdsr_pkg::HS_IDLE: begin
                if (cmdValid) begin
                    hs_nxt.op      = cmdOp;
                    hs_nxt.tx      = {cmdOp, wrData};
                    hs_nxt.din     = cmdOp[7];
                    hs_nxt.div     = 8'h0;
                    hs_nxt.falls   = '0;
                    hs_nxt.setBit  = 8'h0;
                    hs_nxt.wordBit = 5'h0;
                    hs_nxt.wordIdx = 4'h0;
                    hs_nxt.devIdx  = hs_r.chain ? '0 : cmdDev;
                    hs_nxt.csN     = hs_r.chain ? '0 : ~(N_DEV'(1) << cmdDev);
                    hs_nxt.total   = FW'(mdsr_pkg::CMD_BITS);
                    if (cmdOp == mdsr_pkg::CMD_WREG1) begin
                        hs_nxt.chain = wrData[mdsr_pkg::CFG_CHAIN_BIT];
                        hs_nxt.rate  = wrData[mdsr_pkg::CFG_RATE_LSB +: mdsr_pkg::RATE_W];
                        hs_nxt.total = FW'(mdsr_pkg::CMD_BITS + mdsr_pkg::REG_BITS);
                    end else if (cmdOp == mdsr_pkg::CMD_RREG1) begin
                        // The edge that takes the last command bit already launches the first reply bit.
                        hs_nxt.total = FW'(mdsr_pkg::CMD_BITS + mdsr_pkg::REG_BITS - 1);
                    end else if (cmdOp == mdsr_pkg::CMD_RDATA) begin
                        hs_nxt.total = hs_r.chain ?
                            FW'(mdsr_pkg::CMD_BITS + N_DEV * (int'(fb) + 1) - 2) :
                            FW'(mdsr_pkg::CMD_BITS + int'(fb) - 1);
                    end
                    hs_nxt.state = mdsr_pkg::HS_SHIFT;
                end
            end
            mdsr_pkg::HS_SHIFT: begin
                hs_nxt.div = hs_r.div + 8'h1;
                if (hs_r.div == DIV_LAST) begin
                    hs_nxt.div  = 8'h0;
                    hs_nxt.sclk = ~hs_r.sclk;
                    if (hs_r.sclk) begin
                        hs_nxt.falls = hs_r.falls + FW'(1);
                        hs_nxt.tx    = {hs_r.tx[14:0], 1'b0};
                        hs_nxt.din   = hs_r.tx[14];
                        if (hs_r.falls >= FW'(mdsr_pkg::CMD_BITS - 1)) begin
                            if (hs_r.op == mdsr_pkg::CMD_RREG1) begin
                                // The addressed device answers register reads; in chain mode only the first one reaches the host.
                                hs_nxt.rdData = {hs_r.rdData[6:0], hs_r.doS2};
                                hs_nxt.rdValid = (hs_r.falls + FW'(1) == hs_r.total);
                            end else if (hs_r.op == mdsr_pkg::CMD_RDATA) begin
                                if (hs_r.setBit == fb) begin
                                    hs_nxt.setBit  = 8'h0;
                                    hs_nxt.devIdx  = hs_r.devIdx + DW'(1);
                                    hs_nxt.wordIdx = 4'h0;
                                end else begin
                                    hs_nxt.setBit  = hs_r.setBit + 8'h1;
                                    hs_nxt.rxSh    = {hs_r.rxSh[22:0], hs_r.doS2};
                                    hs_nxt.wordBit = hs_r.wordBit + 5'h1;
                                    if (hs_r.wordBit + 5'h1 == wlen) begin
                                        hs_nxt.rxValid = 1'b1;
                                        hs_nxt.rxWord  = (wlen == 5'(mdsr_pkg::CHAN_BITS_LO)) ?
                                            {8'h0, hs_r.rxSh[14:0], hs_r.doS2} : {hs_r.rxSh[22:0], hs_r.doS2};
                                        hs_nxt.wordBit = 5'h0;
                                        hs_nxt.wordIdx = hs_r.wordIdx + 4'h1;
                                    end
                                end
                            end
                        end
                        if (hs_r.falls + FW'(1) == hs_r.total) begin
                            hs_nxt.state = mdsr_pkg::HS_TAIL;
                        end
                    end
                end
            end
            mdsr_pkg::HS_TAIL: begin
                hs_nxt.div = hs_r.div + 8'h1;
                if (hs_r.div == DIV_LAST) begin
                    hs_nxt.div   = 8'h0;
                    hs_nxt.csN   = '1;
                    hs_nxt.state = mdsr_pkg::HS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            hs_r       <= '0;
            hs_r.state <= mdsr_pkg::HS_IDLE;
            hs_r.csN   <= '1;
        end else begin
            hs_r <= hs_nxt;
        end
    end

    assign cmdReady     = (hs_r.state == mdsr_pkg::HS_IDLE);
    assign lnk.sclk     = hs_r.sclk;
    assign lnk.din      = hs_r.din;
    assign lnk.csN      = hs_r.csN;
    assign lnk.chainWired = hs_r.chain;
    assign rxValid      = hs_r.rxValid;
    assign rxWord       = hs_r.rxWord;
    assign rxDev        = hs_r.devIdx;
    assign rxChan       = hs_r.wordIdx;
    assign rdValid      = hs_r.rdValid;
    assign rdData       = hs_r.rdData;
    // Conversions are started by command, so the start pin stays low.
    assign convStartPin = 1'b0;
    assign chainTooLong = hs_r.tooLong;

endmodule // mdsr_host

// File: tb/mdsr_link_sva.sv
`timescale 1ns/1ps
module mdsr_link_sva #(
    parameter int N_DEV = 2
) (
    input wire logic             core_clk,
    input wire logic             reset,
    input wire logic             sclk,
    input wire logic             din,
    input wire logic [N_DEV-1:0] csN,
    input wire logic [N_DEV-1:0] devDout,
    input wire logic [N_DEV-1:0] devDoutOe,
    input wire logic [N_DEV-1:0] chainIn,
    input wire logic             chainWired,
    input wire logic             busDout
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // A short level on the link clock would starve the two sync flops in the host.
    sequence sHalf;
        $stable(sclk) [*3];
    endsequence
    sequence sLead;
        !sclk [*3];
    endsequence
    AST_RELEASE: assert property ((devDoutOe & csN) == '0)
        else $error("data output driven while deselected");
    AST_DRIVE: assert property ((~csN & ~devDoutOe) == '0)
        else $error("selected device not driving");
    AST_LAST_GND: assert property (chainIn[N_DEV-1] == 1'b0)
        else $error("last chain input not grounded");
    AST_FEED: assert property (chainIn[N_DEV-2:0] == devDout[N_DEV-1:1])
        else $error("chain input not fed from next device");
    AST_BUS: assert property (busDout == (chainWired ? (devDout[0] & devDoutOe[0]) : |(devDout & devDoutOe)))
        else $error("shared output line wrong");
    AST_IDLE: assert property (&csN |-> !sclk)
        else $error("link clock running outside a frame");
    AST_HALF: assert property ($changed(sclk) |=> sHalf)
        else $error("link clock level too short");
    AST_LEAD: assert property ($fell(csN[0]) |-> sLead)
        else $error("link clock edge too soon after select");
endmodule // mdsr_link_sva

// File: tb/multi_device_serial_readout_test.sv
`timescale 1ns/1ps
module multi_device_serial_readout_test;
    localparam int ND    = 2;
    localparam int DRATE = 4000;
    logic                             core_clk = 1'b0;
    logic                             reset    = 1'b1;
    logic                             cmdValid = 1'b0;
    logic [7:0]                       cmdOp    = 8'h00;
    logic [7:0]                       cmdData  = 8'h00;
    logic [1:0]                       cmdDev   = 2'h0;
    logic                             cmdReady, rxValid, rdValid, convStartPin, chainTooLong;
    logic [23:0]                      rxWord;
    logic [1:0]                       rxDev;
    logic [3:0]                       rxChan;
    logic [7:0]                       rdData;
    logic [ND-1:0]                    sVal = '0;
    logic [ND-1:0]                    sRdy, chM, oscEn, cStart;
    logic [2:0]                       rSel [ND];
    logic [mdsr_pkg::STATUS_BITS-1:0] sSt  [ND];
    logic [mdsr_pkg::CHAN_RAW_W-1:0]  sCh  [ND];
    logic [31:0]                      got  [$];
    int                               bad_count   = 0;
    int                               comparisons = 0;
    int                               starts      = 0;
    int                               rdSeen      = 0;

    mdsr_if #(.N_DEV(ND)) lnk ();
    mdsr_host #(.N_DEV(ND), .DATA_RATE_HZ(DRATE)) mdsr_host_i (.core_clk, .reset, .lnk(lnk.host), .cmdValid,
        .cmdOp, .cmdData, .cmdDev, .cmdReady, .rxValid, .rxWord, .rxDev, .rxChan, .rdValid, .rdData,
        .convStartPin, .chainTooLong);
    for (genvar i = 0; i < ND; i++) begin : g_dev
        mdsr_device #(.DEV_IDX(i)) mdsr_device_i (.lnk(lnk.device), .core_clk, .reset, .sampleValid(sVal[i]),
            .sampleStatus(sSt[i]), .sampleChans(sCh[i]), .sampleReady(sRdy[i]), .chainMode(chM[i]),
            .rateSelect(rSel[i]), .oscClkOutEn(oscEn[i]), .convStart(cStart[i]));
    end
    mdsr_link_sva #(.N_DEV(ND)) mdsr_link_sva_i (.core_clk, .reset, .sclk(lnk.sclk), .din(lnk.din),
        .csN(lnk.csN), .devDout(lnk.devDout), .devDoutOe(lnk.devDoutOe), .chainIn(lnk.chainIn),
        .chainWired(lnk.chainWired), .busDout(lnk.busDout));

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (rxValid === 1'b1)
            got.push_back({2'h0, rxDev, rxChan, rxWord});
        starts <= starts + $countones(cStart);
        rdSeen <= rdSeen + int'(rdValid === 1'b1);
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] act);
        comparisons++;
        if (exp !== act) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, act);
        end
    endtask

    // Every wait is bounded; running out ends the run as a failure.
    task automatic waitHigh(int w);
        for (int n = 0; (w == 0 ? cmdReady : sRdy[w-1]) !== 1'b1; n++) begin
            if (n > 20000) begin
                chk("handshake", 32'h1, 32'h0);
                print_verdict();
            end
            @(negedge core_clk);
        end
    endtask

    task automatic send(logic [7:0] op, logic [7:0] dat, int dev);
        waitHigh(0);
        cmdOp = op;
        cmdData = dat;
        cmdDev = 2'(dev);
        cmdValid = 1'b1;
        @(negedge core_clk);
        cmdValid = 1'b0;
        @(negedge core_clk);
        waitHigh(0);
    endtask

    task automatic load(int d);
        sSt[d] = 24'($urandom());
        for (int k = 0; k < 6; k++)
            sCh[d][32*k +: 32] = $urandom();
        sVal[d] = 1'b1;
        waitHigh(d + 1);
        @(negedge core_clk);
        sVal[d] = 1'b0;
    endtask

    function automatic logic [23:0] expWord(int d, int k, logic [2:0] rate);
        logic [23:0] w;
        w = (k == 0) ? sSt[d] : sCh[d][191 - 24 * (k - 1) -: 24];
        return (k > 0 && rate <= mdsr_pkg::RATE_LOWRES_MAX) ? {8'h00, w[23:8]} : w;
    endfunction

    task automatic readCheck(logic chain, int dev, logic [2:0] rate);
        int i;
        i = 0;
        got.delete();
        send(mdsr_pkg::CMD_RDATA, 8'h00, dev);
        for (int d = 0; d < ND; d++)
            if (chain || d == dev)
                for (int k = 0; k < 9; k++) begin
                    chk("word", {2'h0, 2'(d), 4'(k + 1), expWord(d, k, rate)}, got[i]);
                    i++;
                end
        chk("words", 32'(i), 32'(got.size()));
    endtask

    initial begin
        logic [7:0] cfg;
        logic [2:0] rate;
        logic       ch;
        logic       chOn;
        void'($urandom(8783));
        chOn = 1'b0;
        for (int d = 0; d < ND; d++) begin
            sSt[d] = '0;
            sCh[d] = '0;
        end
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        for (int it = 0; it < 5; it++) begin
            ch = it[0];
            rate = (it < 2) ? 3'(it + 1) : 3'($urandom_range(7));
            // The oscillator bit is set on purpose; chain mode must keep it off.
            cfg = {1'b0, ch, 1'b1, 2'b00, rate};
            // While the host runs the chain, one write must reach every device.
            for (int d = 0; d < (chOn ? 1 : ND); d++)
                send(mdsr_pkg::CMD_WREG1, cfg, d);
            chOn = ch;
            repeat (10) @(negedge core_clk);
            for (int d = 0; d < ND; d++) begin
                chk("chain", 32'(ch), 32'(chM[d]));
                chk("rate", 32'(rate), 32'(rSel[d]));
                chk("osc", 32'(!ch), 32'(oscEn[d]));
            end
            rdSeen = 0;
            send(mdsr_pkg::CMD_RREG1, 8'h00, ch ? 0 : ND - 1);
            chk("reg", 32'(ch ? cfg & 8'hdf : cfg), 32'(rdData));
            chk("rd pulses", 32'h1, 32'(rdSeen));
            starts = 0;
            send(mdsr_pkg::CMD_START, 8'h00, 0);
            repeat (6) @(negedge core_clk);
            chk("starts", ch ? 32'h2 : 32'h1, 32'(starts));
            chk("start pin", 32'h0, 32'(convStartPin));
            for (int d = 0; d < ND; d++)
                load(d);
            for (int d = 0; d < (ch ? 1 : ND); d++)
                send(mdsr_pkg::CMD_RDATA, 8'h00, d);
            for (int d = 0; d < (ch ? 1 : ND); d++)
                readCheck(ch, d, rate);
            $display("test %0d done chain %0d rate %0d", it, ch, rate);
        end
        chk("too long", 32'(ND * mdsr_pkg::FRAME_MAX * DRATE > 25000000 / 8), 32'(chainTooLong));
        print_verdict();
    end
endmodule // multi_device_serial_readout_test
